// File: design/wrsu_cfg.svh
// Offsets, field positions, reset values and timing counts of the watchdog unit
`ifndef WRSU_CFG_SVH
`define WRSU_CFG_SVH
// Register byte offsets
`define WRSU_CTRL_OFS   12'h000
`define WRSU_CMD_OFS    12'h004
`define WRSU_COUNT_OFS  12'h008
`define WRSU_IRQST_OFS  12'h00C
`define WRSU_IRQMSK_OFS 12'h010
// Control register fields
`define WRSU_PRESC_BIT  0
`define WRSU_BIDIR_BIT  1
`define WRSU_REL_LSB    8
`define WRSU_FLAG_LSB   16
`define WRSU_END_OF_INIT_INSTR_BIT  24
`define WRSU_DIS_BIT    25
// Command register bits
`define WRSU_CMD_SERV   0
`define WRSU_CMD_END_OF_INIT_INSTR  1
`define WRSU_CMD_SOFTWARE_RESET_INSTR   2
`define WRSU_CMD_DIS    3
// Reset values
`define WRSU_RELOAD_RST 8'h00
`define WRSU_CNT_RST    16'h0000
// Prescaler divide ratios
`define WRSU_DIV_SLOW   128
`define WRSU_DIV_FAST   2
// Timing: clock period, filter minimum and long threshold
`define WRSU_CLK_PS     8000
`define WRSU_TCL_PS     (`WRSU_CLK_PS / 2)
`define WRSU_FILT_NS    500
`define WRSU_MIN_TCL    4
`define WRSU_LONG_TCL   (1032 + 12)
`define WRSU_FILT_CYC   ((`WRSU_FILT_NS * 1000 + `WRSU_CLK_PS - 1) / `WRSU_CLK_PS)
`define WRSU_MIN_CYC    ((`WRSU_MIN_TCL * `WRSU_TCL_PS + `WRSU_CLK_PS - 1) / `WRSU_CLK_PS)
`define WRSU_SHORT_CYC  ((`WRSU_FILT_CYC > `WRSU_MIN_CYC) ? `WRSU_FILT_CYC : `WRSU_MIN_CYC)
`define WRSU_LONG_CYC   ((`WRSU_LONG_TCL * `WRSU_TCL_PS) / `WRSU_CLK_PS + `WRSU_SHORT_CYC)
`define WRSU_HOLD_CYC   512
`endif

// File: design/wrsu_pkg.sv
// Types shared by the watchdog and reset source unit
package wrsu_pkg;
  // Internal reset sequencer states
  typedef enum logic [0:0] {
    WRSU_RUN,
    WRSU_HOLD
  } wrsu_seq_t;
  // Reset cause flag vector: {pon, long, short, sw, wdt}
  typedef logic [4:0] wrsu_flags_t;
endpackage

// File: design/wrsu_top.sv
// Watchdog counter with reset source flags and APB register access
//
// Added by the designer: the register offsets and the APB slave port.
`include "wrsu_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wrsu_top
  import wrsu_pkg::*;
#(
  parameter int HOLD_CYC = `WRSU_HOLD_CYC // Internal reset length
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  input  wire logic        reset_input_pin_i,
  output logic             reset_input_pin_o,
  output logic             reset_input_pin_oe_o,
  input  wire logic        reset_mode_pin_i,
  output logic             reset_output_pin_n_o,
  output logic             int_reset_o
);

  localparam int LW = 10; // Low-width counter bits
  localparam logic [LW-1:0] SHORT_C = LW'(`WRSU_SHORT_CYC);
  localparam logic [LW-1:0] LONG_C  = LW'(`WRSU_LONG_CYC);
  localparam logic [9:0]    HOLD_C  = 10'(HOLD_CYC - 1);

  // Synchronisers for the two pins
  logic [2:0] rin_sync_ff;   // Reset input pin stages
  logic [2:0] mode_sync_ff;  // Reset mode pin stages
  logic       rin_ff;        // Filtered reset input level
  logic       mode_ff;       // Filtered reset mode level

  // Watchdog state
  logic [15:0] cnt_ff;       // Watchdog counter
  logic [6:0]  pre_ff;       // Prescaler
  logic [7:0]  reload_ff;    // Reload value field
  logic        presc_ff;     // Clock prescale select
  logic        bidir_ff;     // Bidir reset enable
  logic        end_of_init_instr_ff;     // End of init executed
  logic        dis_ff;       // Watchdog disabled
  wrsu_flags_t flags_ff;     // Reset cause flags

  // Reset sequencer
  wrsu_seq_t   seq_ff;
  logic [9:0]  hold_ff;      // Hold-time counter
  logic        drv_ff;       // Driving reset input pin
  logic [LW-1:0] low_ff;     // Low-width of input pulse

  // Interrupt registers
  logic [2:0]  ist_ff;       // Sticky status
  logic [2:0]  imsk_ff;      // Mask
  logic        irq_ff;

  // Bus output registers
  logic [31:0] rdata_ff;
  logic        ready_ff;
  logic        err_ff;

  // Bus decode
  wire acc    = psel_i & penable_i;
  wire done   = acc & ready_ff;
  wire wr     = done & pwrite_i;
  wire rd     = done & ~pwrite_i;
  wire a_ctrl = (paddr_i == `WRSU_CTRL_OFS);
  wire a_cmd  = (paddr_i == `WRSU_CMD_OFS);
  wire a_cnt  = (paddr_i == `WRSU_COUNT_OFS);
  wire a_ist  = (paddr_i == `WRSU_IRQST_OFS);
  wire a_imsk = (paddr_i == `WRSU_IRQMSK_OFS);
  wire a_hit  = a_ctrl | a_cmd | a_cnt | a_ist | a_imsk;

  // Command strobes, taken at the completing edge
  wire c_wr   = wr & a_cmd;
  wire c_serv = c_wr & pwdata_i[`WRSU_CMD_SERV];
  wire c_ein  = c_wr & pwdata_i[`WRSU_CMD_END_OF_INIT_INSTR];
  wire c_software_reset_instr = c_wr & pwdata_i[`WRSU_CMD_SOFTWARE_RESET_INSTR];
  wire c_dis  = c_wr & pwdata_i[`WRSU_CMD_DIS];

  // Prescaler tick: every 2 or 128 clocks
  wire [6:0] pre_top = presc_ff ? 7'(`WRSU_DIV_SLOW - 1)
                                : 7'(`WRSU_DIV_FAST - 1);
  wire tick  = (pre_ff >= pre_top);
  wire run   = (seq_ff == WRSU_RUN) & ~dis_ff;
  // Overflow is the wrap from all ones
  wire ovf   = run & tick & ~c_serv
             & (cnt_ff == 16'hFFFF);

  // Pin-driven hardware reset sequence
  wire hw_low  = ~rin_ff & mode_ff & ~drv_ff;
  wire hw_end  = ~hw_low & (low_ff != '0);
  wire is_shrt = (low_ff >= SHORT_C);
  wire is_long = (low_ff > LONG_C);
  // A recognised pin pulse resets counter and control fields but runs no hold sequence
  wire hw_rst  = hw_end & is_shrt;

  // Internal reset start from watchdog or software
  wire start   = ovf | c_software_reset_instr;
  wire seq_end = (seq_ff == WRSU_HOLD) & (hold_ff == HOLD_C);

  // Read data selection
  wire [31:0] ctrl_rd = {6'h00, dis_ff, end_of_init_instr_ff,
                         3'h0, flags_ff,
                         reload_ff, 6'h00, bidir_ff, presc_ff};
  wire [31:0] rsel = a_ctrl ? ctrl_rd
                   : a_cnt  ? {16'h0000, cnt_ff}
                   : a_ist  ? {29'h0, ist_ff}
                   : a_imsk ? {29'h0, imsk_ff}
                   : 32'h00000000;

  // Interrupt events: overflow, software reset, hw pulse seen
  wire [2:0] iev = {hw_end & is_shrt, c_software_reset_instr, ovf};
  wire       iclr = rd & a_ist;

  // Three-stage pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rin_sync_ff  <= 3'h7;
      mode_sync_ff <= 3'h0;
    end
    else
    begin
      rin_sync_ff  <= {rin_sync_ff[1:0], reset_input_pin_i};
      mode_sync_ff <= {mode_sync_ff[1:0], reset_mode_pin_i};
    end
  end

  // Filtered levels change once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rin_ff  <= 1'b1;
      mode_ff <= 1'b0;
    end
    else
    begin
      if (rin_sync_ff[2] == rin_sync_ff[1])
        rin_ff <= rin_sync_ff[2];
      if (mode_sync_ff[2] == mode_sync_ff[1])
        mode_ff <= mode_sync_ff[2];
    end
  end

  // Prescaler, restarted on service
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run || tick || c_serv)
      pre_ff <= 7'h00;
    else
      pre_ff <= pre_ff + 7'h01;
  end

  // Watchdog counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || seq_ff == WRSU_HOLD || hw_rst)
      cnt_ff <= `WRSU_CNT_RST;
    else if (c_serv)
      cnt_ff <= {reload_ff, 8'h00};
    else if (run && tick)
      cnt_ff <= cnt_ff + 16'h0001;
  end

  // Control fields, returned to defaults by any reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || start || hw_rst)
    begin
      reload_ff <= `WRSU_RELOAD_RST;
      presc_ff  <= 1'b0;
      bidir_ff  <= 1'b0;
      end_of_init_instr_ff  <= 1'b0;
      dis_ff    <= 1'b0;
    end
    else
    begin
      if (wr && a_ctrl)
      begin
        // Software should rewrite this before servicing
        reload_ff <= pwdata_i[`WRSU_REL_LSB +: 8];
        presc_ff  <= pwdata_i[`WRSU_PRESC_BIT];
        bidir_ff  <= pwdata_i[`WRSU_BIDIR_BIT];
      end
      if (c_ein)
        end_of_init_instr_ff <= 1'b1;
      // Disable ignored once end of init has run
      if (c_dis && !end_of_init_instr_ff)
        dis_ff <= 1'b1;
    end
  end

  // Reset cause flags: {pon, long, short, sw, wdt}
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_ff <= 5'b10000;
    else if (ovf)
      flags_ff <= 5'b00001;
    else if (c_software_reset_instr)
      flags_ff <= 5'b00010;
    else if (hw_end && is_shrt)
      flags_ff <= {1'b0, is_long, 3'b100};
    else if (c_ein)
      flags_ff <= 5'b00000;
  end

  // Width of a low pulse with mode pin high
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !hw_low)
      low_ff <= '0;
    else if (low_ff != '1)
      low_ff <= low_ff + LW'(1);
  end

  // Internal reset sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_ff  <= WRSU_RUN;
      hold_ff <= 10'h000;
      drv_ff  <= 1'b0;
    end
    else
    begin
      case (seq_ff)
        WRSU_RUN:
        begin
          hold_ff <= 10'h000;
          if (start)
          begin
            seq_ff <= WRSU_HOLD;
            // Drive input pin only if bidir on and mode high
            drv_ff <= bidir_ff & mode_ff;
          end
        end
        WRSU_HOLD:
        begin
          hold_ff <= hold_ff + 10'h001;
          if (seq_end)
          begin
            seq_ff <= WRSU_RUN;
            drv_ff <= 1'b0;
          end
        end
        default:
        begin
          seq_ff <= WRSU_RUN;
        end
      endcase
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ist_ff  <= 3'h0;
      imsk_ff <= 3'h0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      // New event wins over the read clear
      ist_ff <= (iclr ? 3'h0 : ist_ff) | iev;
      if (wr && a_imsk)
        imsk_ff <= pwdata_i[2:0];
      irq_ff <= |(ist_ff & imsk_ff);
    end
  end

  // APB slave: one wait state, error on unmapped address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end
    else if (acc && !ready_ff)
    begin
      ready_ff <= 1'b1;
      err_ff   <= ~a_hit;
      rdata_ff <= pwrite_i ? 32'h00000000 : rsel;
    end
    else
    begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
    end
  end

  // Outputs straight from flip-flops, except the input pin drive value, which is tied low
  assign prdata_o             = rdata_ff;
  assign pready_o             = ready_ff;
  assign pslverr_o            = err_ff;
  assign irq_o                = irq_ff;
  assign reset_input_pin_o    = 1'b0;

  // Pin and internal reset drive registers
  logic oe_ff;
  logic rout_n_ff;
  logic ires_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oe_ff     <= 1'b0;
      rout_n_ff <= 1'b0;
      ires_ff   <= 1'b1;
    end
    else
    begin
      oe_ff     <= drv_ff & (seq_ff == WRSU_HOLD);
      // Output pin low during any internal reset
      rout_n_ff <= ~((seq_ff == WRSU_HOLD) | hw_low);
      ires_ff   <= (seq_ff == WRSU_HOLD) | hw_low;
    end
  end

  assign reset_input_pin_oe_o = oe_ff;
  assign reset_output_pin_n_o = rout_n_ff;
  assign int_reset_o          = ires_ff;

endmodule
`default_nettype wire

// File: dv/wrsu_board.sv
// Board model: reset button, mode strap, pulled-up reset input wire
`timescale 1ns/1ps
`default_nettype none
module wrsu_board (
  input  wire logic oe_i,  // Unit pulls the wire
  input  wire logic drv_i, // Value the unit drives
  output logic      pin_o, // Resolved wire level
  output logic      mode_o // Reset mode strap
);
  logic btn_low = 1'b0; // Button holds the wire low
  logic mode_lv = 1'b1; // Strap level
  // Pull-up wins unless a party pulls low
  assign pin_o = !(btn_low || (oe_i && !drv_i));
  assign mode_o = mode_lv;
endmodule
`default_nettype wire

// File: dv/wrsu_top_bench.sv
// Directed APB bench for the watchdog and reset source unit
`timescale 1ns/1ps
`default_nettype none
`include "wrsu_cfg.svh"
module wrsu_top_bench;
  import wrsu_pkg::*;
  logic        clk_i, rst_i, psel, pen, pwr, prdy, perr, irq, pi, po, oe, md, ro, ir, ev, oes;
  logic [11:0] pa;
  logic [31:0] pw, prd, rv;
  int          errors = 0, total_checks = 0, n;
  wrsu_top #(.HOLD_CYC(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .irq_o(irq), .reset_input_pin_i(pi), .reset_input_pin_o(po),
    .reset_input_pin_oe_o(oe), .reset_mode_pin_i(md), .reset_output_pin_n_o(ro),
    .int_reset_o(ir));
  wrsu_board board (.oe_i(oe), .drv_i(po), .pin_o(pi), .mode_o(md));
  // Clock of 8 ns
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Note any drive of the input pin
  always @(posedge clk_i)
    if (oe === 1'b1) oes <= 1'b1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (prdy !== 1'b1 && k < 20);
    rv = prd;
    ev = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  // Wait out an internal reset
  task automatic settle();
    int k = 0;
    repeat (2) @(posedge clk_i);
    while (ir !== 1'b0 && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task automatic pulse(input int w);
    board.btn_low <= 1'b1;
    repeat (w) @(posedge clk_i);
    board.btn_low <= 1'b0;
    settle();
  endtask
  // Service, then time the overflow
  task automatic wdt_to(input logic [31:0] c, input int lo, input int hi);
    apb(1'b1, `WRSU_CTRL_OFS, c);
    apb(1'b1, `WRSU_CMD_OFS, 32'h1);
    apb(1'b0, `WRSU_COUNT_OFS, 32'h0);
    chk("count_high", c[15:8], rv[15:8]);
    n = 0;
    while (ir !== 1'b1 && n < 40000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("timeout", 1, n >= lo && n <= hi);
    chk("rst_out_low", 0, ro);
    settle();
    chk("rst_out_high", 1, ro);
    chk("irq_wdt", 1, irq);
    rd(`WRSU_IRQST_OFS, 32'h1, "status_wdt");
    rd(`WRSU_CTRL_OFS, 32'h0001_0000, "flags_wdt");
    chk("irq_clr", 0, irq);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    repeat (100000) @(posedge clk_i);
    errors++;
    summarize();
  end
  initial
  begin
    {rst_i, psel, pen, pwr, pa, pw, oes} = {1'b1, 48'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`WRSU_CTRL_OFS, 32'h0010_0000, "flags_por");
    apb(1'b0, `WRSU_COUNT_OFS, 32'h0);
    n = rv;
    apb(1'b0, `WRSU_COUNT_OFS, 32'h0);
    chk("count_runs", 1, rv != n);
    apb(1'b1, `WRSU_CMD_OFS, 32'h8);
    rd(`WRSU_CTRL_OFS, 32'h0210_0000, "disable_early");
    apb(1'b1, `WRSU_CMD_OFS, 32'h4);
    settle();
    rd(`WRSU_CTRL_OFS, 32'h0002_0000, "flags_sw");
    chk("irq_masked", 0, irq);
    rd(`WRSU_IRQST_OFS, 32'h2, "status_sw");
    apb(1'b1, `WRSU_IRQMSK_OFS, 32'h7);
    wdt_to(32'h0000_FF00, 500, 515);
    wdt_to(32'h0000_FF01, 32755, 32775);
    for (int m = 1; m >= 0; m--)
    begin
      board.mode_lv <= m[0];
      apb(1'b1, `WRSU_CTRL_OFS, 32'h2);
      oes <= 1'b0;
      apb(1'b1, `WRSU_CMD_OFS, 32'h4);
      settle();
      chk("bidir_drive", m, oes);
    end
    board.mode_lv <= 1'b1;
    apb(1'b1, `WRSU_CMD_OFS, 32'h2);
    rd(`WRSU_CTRL_OFS, 32'h0100_0000, "end_of_init_instr_clear");
    apb(1'b1, `WRSU_CMD_OFS, 32'h8);
    rd(`WRSU_CTRL_OFS, 32'h0100_0000, "disable_late");
    pulse(30);
    rd(`WRSU_CTRL_OFS, 32'h0100_0000, "flags_spike");
    pulse(100);
    rd(`WRSU_CTRL_OFS, 32'h0004_0000, "flags_short");
    rd(`WRSU_IRQST_OFS, 32'h6, "status_hw");
    apb(1'b1, `WRSU_CMD_OFS, 32'h2);
    pulse(700);
    rd(`WRSU_CTRL_OFS, 32'h000C_0000, "flags_long");
    rd(12'h0FC, 32'h0, "unmapped_data");
    chk("unmapped_err", 1, ev);
    summarize();
  end
endmodule
`default_nettype wire

// File: dv/wrsu_top_sva.sv
// Port level checker for the watchdog and reset source unit
`timescale 1ns/1ps
`default_nettype none
module wrsu_top_sva
  import wrsu_pkg::*;
#(
  parameter int HOLD_CYC = 16 // Internal reset length
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_o,
  input wire logic        reset_input_pin_i,
  input wire logic        reset_input_pin_o,
  input wire logic        reset_input_pin_oe_o,
  input wire logic        reset_mode_pin_i,
  input wire logic        reset_output_pin_n_o,
  input wire logic        int_reset_o
);
  // All checks on the one clock, quiet in reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ready_pulse : assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_ready_wait : assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait");
  a_err_ready : assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_err_data : assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  a_out_low : assert property (int_reset_o |-> !reset_output_pin_n_o)
    else $error("reset output high during internal reset");
  a_drive_in_reset : assert property (reset_input_pin_oe_o |-> int_reset_o)
    else $error("input pin driven outside internal reset");
  a_pin_resets : assert property ((!reset_input_pin_i && reset_mode_pin_i)[*8] |-> int_reset_o)
    else $error("low input pin gave no internal reset");
  a_hold_min : assert property ($rose(int_reset_o) && $past(reset_input_pin_i, 2) |-> int_reset_o[*8])
    else $error("internal reset too short");
  a_drive_low : assert property (reset_input_pin_oe_o |-> !reset_input_pin_o)
    else $error("input pin driven high");
  c_int_reset : cover property ($rose(int_reset_o));
  c_drive : cover property ($rose(reset_input_pin_oe_o));
  c_refuse : cover property (pslverr_o);
endmodule
bind wrsu_top wrsu_top_sva #(.HOLD_CYC(HOLD_CYC)) sva (.*);
`default_nettype wire
